// >>> src/mop_cfg.svh
// constants of the multifunction output stage: offsets, fields, resets,
// source codes and timing; included by the top and usable by a bench
// Behaviour
// - four output modes: off, digital, analog, pulse
// - unselected mode paths disabled, one source drives
// - default mode is 24 V PWM analog
// - analog source select, 0 off, frequencies to fmax
// - temperatures map linearly over 0 to 100 C
// - codes 101 to 133 keep the sign
// - linear map onto 0% to 100% voltage span
// - overrange rises above 100% level, saturates 24 V
// - pulse source select, absolute value always used
// - pulses per revolution from division marks 30..8192
// - below 30 Hz no pulses are output
`ifndef MOP_CFG_SVH
`define MOP_CFG_SVH

// register byte offsets
`define MOP_OFF_MODE 12'h000
`define MOP_OFF_ASRC 12'h004
`define MOP_OFF_VOLT 12'h008
`define MOP_OFF_PULSE 12'h00C
`define MOP_OFF_STAT 12'h010

// field positions
`define MOP_MODE_LSB 0
`define MOP_ASRC_LSB 0
`define MOP_V100_LSB 0
`define MOP_V0_LSB 8
`define MOP_PSRC_LSB 0
`define MOP_MARKS_LSB 16
`define MOP_STAT_LIVE_BIT 8
`define MOP_STAT_BUSY_BIT 9

// reset values; voltages in 0.1 V
`define MOP_RST_MODE 2'h2
`define MOP_RST_ASRC 8'h01
`define MOP_RST_V100 8'h64
`define MOP_RST_V0 8'h00
`define MOP_RST_PSRC 3'h0
`define MOP_RST_MARKS 14'h0400

// limits: 22.0 V, 24.0 V, 30 and 8192 marks
`define MOP_V100_MAX 8'hDC
`define MOP_V_SAT 8'hF0
`define MOP_MARKS_MIN 14'h001E
`define MOP_MARKS_MAX 14'h2000

// analog source codes
`define MOP_ASRC_FS 8'h01
`define MOP_ASRC_FS_BAND 8'h02
`define MOP_ASRC_SPEED 8'h03
`define MOP_ASRC_ACT 8'h07
`define MOP_ASRC_TIN 8'h20
`define MOP_ASRC_TSINK 8'h21
`define MOP_ASRC_AIN 8'h28
`define MOP_ASRC_SIGN_LO 8'h65
`define MOP_ASRC_SIGN_HI 8'h85
`define MOP_ASRC_SIGN_OFS 8'h64
// full scales: 100 C in 0.1 C, 10.00 V in 0.01 V
`define MOP_TEMP_FULL 19'h0_03E8
`define MOP_AIN_FULL 19'h0_03E8

// pulse source codes
`define MOP_PSRC_ACT 3'h1
`define MOP_PSRC_FS 3'h2
`define MOP_PSRC_ENC 3'h3
`define MOP_PSRC_PIN 3'h5

// timing; frequencies carry 0.01 Hz per count
`define MOP_CLK_HZ 33'h0_017D_7840
`define MOP_FREQ_SCALE 33'h0_0000_0064
`define MOP_ACC_MOD (`MOP_CLK_HZ * `MOP_FREQ_SCALE)
`define MOP_PULSE_FMIN_HZ 33'h0_0000_001E
`define MOP_PULSE_FMIN (`MOP_PULSE_FMIN_HZ * `MOP_FREQ_SCALE)
`define MOP_PULSE_HIGH_NS 33'h0_0000_07D0
`define MOP_PULSE_HIGH_CYC \
  ((`MOP_PULSE_HIGH_NS * (`MOP_CLK_HZ / 33'h0_000F_4240) + 33'h0_0000_03E7) / 33'h0_0000_03E8)

`endif

// >>> src/mop_pkg.sv
// types of the multifunction output stage
// assumes constants come from mop_cfg.svh
package mop_pkg;
  typedef enum logic [1:0] {
    MOP_MODE_OFF,
    MOP_MODE_DIG,
    MOP_MODE_ANA,
    MOP_MODE_PULSE
  } mop_mode_e;

  typedef enum logic {
    MOP_DIV_IDLE,
    MOP_DIV_RUN
  } mop_div_state_e;

  // frequencies in 0.01 Hz, temperatures in 0.1 C, analog input in 0.01 V
  typedef struct packed {
    logic [17:0] stator_freq;
    logic [17:0] actual_freq;
    logic [17:0] speed_freq;
    logic [17:0] enc1_freq;
    logic [17:0] pulse_in_freq;
    logic [17:0] min_freq;
    logic [17:0] max_freq;
    logic [17:0] inside_temp;
    logic [17:0] sink_temp;
    logic [17:0] multi_input_analog_value;
  } mop_actual_s;
endpackage : mop_pkg

// >>> src/mop_div.sv
`timescale 1ns/1ns
// restoring divider, one quotient bit per clock
// assumes num and den hold still for the start cycle only
module mop_div #(
  parameter int NUM_W = 32,
  parameter int DEN_W = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [DEN_W-1:0] den,
  output logic busy,
  output logic done,
  output logic [NUM_W-1:0] quot
);
  localparam int CW = $clog2(NUM_W + 1);
  generate
    if (NUM_W < 2 || DEN_W < 1)
    begin : g_bad_width
      $error("mop_div: NUM_W must be 2 or more and DEN_W 1 or more");
    end
  endgenerate
  mop_pkg::mop_div_state_e state_r;
  logic [NUM_W-1:0] sh_r;
  logic [DEN_W-1:0] den_r;
  logic [DEN_W-1:0] rem_r;
  logic [CW-1:0] cnt_r;
  wire logic [DEN_W:0] trial = {rem_r, sh_r[NUM_W-1]};
  wire logic fits = trial >= {1'b0, den_r};
  wire logic [DEN_W:0] diff = trial - {1'b0, den_r};
  assign busy = state_r == mop_pkg::MOP_DIV_RUN;
  // a zero divisor always fits, so the quotient saturates to all ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= mop_pkg::MOP_DIV_IDLE;
      sh_r <= '0;
      den_r <= '0;
      rem_r <= '0;
      cnt_r <= '0;
      done <= 1'b0;
      quot <= '0;
    end
    else
    begin
      done <= 1'b0;
      case (state_r)
        mop_pkg::MOP_DIV_IDLE:
        begin
          if (start)
          begin
            sh_r <= num;
            den_r <= den;
            rem_r <= '0;
            cnt_r <= CW'(NUM_W);
            state_r <= mop_pkg::MOP_DIV_RUN;
          end
        end
        mop_pkg::MOP_DIV_RUN:
        begin
          sh_r <= {sh_r[NUM_W-2:0], fits};
          rem_r <= fits ? diff[DEN_W-1:0] : trial[DEN_W-1:0];
          cnt_r <= cnt_r - CW'(1);
          if (cnt_r == CW'(1))
          begin
            quot <= {sh_r[NUM_W-2:0], fits};
            done <= 1'b1;
            state_r <= mop_pkg::MOP_DIV_IDLE;
          end
        end
        default: state_r <= mop_pkg::MOP_DIV_IDLE;
      endcase
    end
  end
endmodule : mop_div

// >>> src/mop_pwm.sv
`timescale 1ns/1ns
// pwm stage of the analog path; duty counts steps of one period
// assumes the high level of the pin is the 24 V supply
module mop_pwm #(
  parameter int STEPS = 240
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [7:0] duty,
  output logic out
);
  generate
    if (STEPS < 2 || STEPS > 256)
    begin : g_bad_steps
      $error("mop_pwm: STEPS must lie in 2..256");
    end
  endgenerate
  logic [7:0] cnt_r;
  logic [7:0] duty_r;
  wire logic last = cnt_r == 8'(STEPS - 1);
  // duty taken at period start so a change never makes a runt pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 8'h00;
      duty_r <= 8'h00;
      out <= 1'b0;
    end
    else
    begin
      cnt_r <= last ? 8'h00 : cnt_r + 8'h01;
      if (last)
      begin
        duty_r <= duty;
      end
      out <= enable && (cnt_r < duty_r);
    end
  end
endmodule : mop_pwm

// >>> src/mop_top.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
// multifunction output stage: apb registers, analog pwm path,
// encoder-style pulse path and the pin selector
// assumes actual values arrive synchronous to pclk in package units
`include "mop_cfg.svh"
module mop_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mop_pkg::mop_actual_s actual,
  input wire logic digital_level,
  output logic multi_output_pin
);
  mop_pkg::mop_mode_e mode_r;
  logic [7:0] ana_src_r;
  logic [7:0] v100_r;
  logic [7:0] v0_r;
  logic [7:0] volt_r;
  logic [2:0] psrc_r;
  logic [13:0] marks_r;
  logic [30:0] inc_r;
  logic [32:0] acc_r;
  logic [7:0] hi_cnt_r;
  logic pulse_r;
  logic pin_r;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;
  logic multi_output_analog_path;

  // register access
  wire logic setup_rd = psel && !penable && !pwrite;
  wire logic wr_take = psel && penable && pwrite;
  wire logic hit_mode = paddr == `MOP_OFF_MODE;
  wire logic hit_asrc = paddr == `MOP_OFF_ASRC;
  wire logic hit_volt = paddr == `MOP_OFF_VOLT;
  wire logic hit_pulse = paddr == `MOP_OFF_PULSE;
  wire logic hit_stat = paddr == `MOP_OFF_STAT;
  wire logic addr_hit = hit_mode | hit_asrc | hit_volt | hit_pulse | hit_stat;

  wire logic [31:0] mode_word = {30'h0000_0000, mode_r} << `MOP_MODE_LSB;
  wire logic [31:0] asrc_word = {24'h00_0000, ana_src_r} << `MOP_ASRC_LSB;
  wire logic [31:0] volt_word = ({24'h00_0000, v0_r} << `MOP_V0_LSB)
    | ({24'h00_0000, v100_r} << `MOP_V100_LSB);
  wire logic [31:0] pulse_word = ({18'h0_0000, marks_r} << `MOP_MARKS_LSB)
    | ({29'h0000_0000, psrc_r} << `MOP_PSRC_LSB);
  wire logic [31:0] stat_word = {24'h00_0000, volt_r}
    | ({31'h0000_0000, div_busy} << `MOP_STAT_BUSY_BIT)
    | ({31'h0000_0000, inc_r != 31'h0000_0000} << `MOP_STAT_LIVE_BIT);
  wire logic [31:0] rd_word = hit_mode ? mode_word
    : hit_asrc ? asrc_word
    : hit_volt ? volt_word
    : hit_pulse ? pulse_word
    : hit_stat ? stat_word
    : 32'h0000_0000;

  // byte lanes that are not strobed keep their old contents
  wire logic [31:0] be_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] wr_word = (rd_word & ~be_mask) | (pwdata & be_mask);
  wire logic [7:0] wr_v100 = wr_word[`MOP_V100_LSB +: 8];
  wire logic [7:0] wr_v0 = wr_word[`MOP_V0_LSB +: 8];
  wire logic [13:0] wr_marks = wr_word[`MOP_MARKS_LSB +: 14];
  // span and mark settings are clamped on write so the datapath never sees them out of range
  wire logic [7:0] v100_nxt = wr_v100 > `MOP_V100_MAX ? `MOP_V100_MAX : wr_v100;
  wire logic [7:0] v0_nxt = wr_v0 > `MOP_V_SAT ? `MOP_V_SAT : wr_v0;
  wire logic [13:0] marks_nxt = wr_marks < `MOP_MARKS_MIN ? `MOP_MARKS_MIN
    : wr_marks > `MOP_MARKS_MAX ? `MOP_MARKS_MAX : wr_marks;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= mop_pkg::mop_mode_e'(`MOP_RST_MODE);
      ana_src_r <= `MOP_RST_ASRC;
      v100_r <= `MOP_RST_V100;
      v0_r <= `MOP_RST_V0;
      psrc_r <= `MOP_RST_PSRC;
      marks_r <= `MOP_RST_MARKS;
    end
    else if (wr_take)
    begin
      if (hit_mode)
      begin
        mode_r <= mop_pkg::mop_mode_e'(wr_word[`MOP_MODE_LSB +: 2]);
      end
      if (hit_asrc)
      begin
        ana_src_r <= wr_word[`MOP_ASRC_LSB +: 8];
      end
      if (hit_volt)
      begin
        v100_r <= v100_nxt;
        v0_r <= v0_nxt;
      end
      if (hit_pulse)
      begin
        psrc_r <= wr_word[`MOP_PSRC_LSB +: 3];
        marks_r <= marks_nxt;
      end
    end
  end

  // read data is caught in the setup cycle and stands through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup_rd)
    begin
      prdata <= rd_word;
    end
  end

  // analog path: pick the quantity and its 100% reference
  wire logic signed [18:0] fs = 19'($signed(actual.stator_freq));
  wire logic [18:0] fmax = {1'b0, actual.max_freq};
  wire logic [18:0] fmin = {1'b0, actual.min_freq};
  wire logic signed [18:0] fs_mag = fs[18] ? -fs : fs;
  wire logic signed_mode = ana_src_r >= `MOP_ASRC_SIGN_LO && ana_src_r <= `MOP_ASRC_SIGN_HI;
  wire logic [7:0] src_base = signed_mode ? ana_src_r - `MOP_ASRC_SIGN_OFS : ana_src_r;
  logic signed [18:0] q_val;
  logic [18:0] q_ref;
  logic q_ok;

  always_comb
  begin
    q_val = 19'sh0_0000;
    q_ref = fmax;
    q_ok = 1'b1;
    case (src_base)
      `MOP_ASRC_FS: q_val = fs;
      `MOP_ASRC_FS_BAND:
      begin
        q_val = fs_mag > $signed(fmin) ? fs_mag - $signed(fmin) : 19'sh0_0000;
        q_ref = fmax > fmin ? fmax - fmin : 19'h0_0000;
      end
      `MOP_ASRC_SPEED: q_val = 19'($signed(actual.speed_freq));
      `MOP_ASRC_ACT: q_val = 19'($signed(actual.actual_freq));
      `MOP_ASRC_TIN:
      begin
        q_val = 19'($signed(actual.inside_temp));
        q_ref = `MOP_TEMP_FULL;
      end
      `MOP_ASRC_TSINK:
      begin
        q_val = 19'($signed(actual.sink_temp));
        q_ref = `MOP_TEMP_FULL;
      end
      `MOP_ASRC_AIN:
      begin
        q_val = 19'($signed(actual.multi_input_analog_value));
        q_ref = `MOP_AIN_FULL;
      end
      default: q_ok = 1'b0;
    endcase
  end

  // signed codes place -100% at the 0% level and +100% at the 100% level
  wire logic [18:0] q_abs = q_val[18] ? 19'(-q_val) : q_val;
  wire logic signed [19:0] q_shift = 20'(q_val) + $signed({1'b0, q_ref});
  wire logic [19:0] num_mag = signed_mode ? (q_shift[19] ? 20'h0_0000 : q_shift)
    : {1'b0, q_abs};
  wire logic [19:0] den_mag = signed_mode ? {q_ref, 1'b0} : {1'b0, q_ref};
  wire logic [31:0] div_num = {num_mag, 12'h000};

  // divider reruns back to back; the fraction is refreshed every 33 clocks
  mop_div #(
    .NUM_W(32),
    .DEN_W(20)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(!div_busy),
    .num(div_num),
    .den(den_mag),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // fraction in 1/4096, held at 16x full scale, far past the 24 V stop
  wire logic [15:0] frac = |div_quot[31:16] ? 16'hFFFF : div_quot[15:0];
  wire logic signed [8:0] dv = $signed({1'b0, v100_r}) - $signed({1'b0, v0_r});
  wire logic signed [25:0] prod = dv * $signed({1'b0, frac});
  wire logic signed [14:0] vsum = $signed({7'h00, v0_r}) + 15'(prod >>> 12);
  wire logic over_sat = vsum > $signed({7'h00, `MOP_V_SAT});
  wire logic [7:0] volt_sat = vsum[14] ? 8'h00 : over_sat ? `MOP_V_SAT : vsum[7:0];
  wire logic ana_ok = q_ok && ana_src_r != 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      volt_r <= 8'h00;
    end
    else if (div_done)
    begin
      volt_r <= ana_ok ? volt_sat : 8'h00;
    end
  end

  mop_pwm #(
    .STEPS(int'(`MOP_V_SAT))
  ) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .enable(mode_r == mop_pkg::MOP_MODE_ANA),
    .duty(volt_r),
    .out(multi_output_analog_path)
  );

  // pulse path: phase accumulator wraps at clock rate times 100
  logic [17:0] p_raw;
  logic p_ok;

  always_comb
  begin
    p_raw = 18'h0_0000;
    p_ok = 1'b1;
    case (psrc_r)
      `MOP_PSRC_ACT: p_raw = actual.actual_freq;
      `MOP_PSRC_FS: p_raw = actual.stator_freq;
      `MOP_PSRC_ENC: p_raw = actual.enc1_freq;
      `MOP_PSRC_PIN: p_raw = actual.pulse_in_freq;
      default: p_ok = 1'b0;
    endcase
  end

  wire logic [16:0] p_abs = p_raw[17] ? 17'(-p_raw) : p_raw[16:0];
  wire logic p_fast = {16'h0000, p_abs} >= `MOP_PULSE_FMIN;
  wire logic p_live = p_ok && p_fast && mode_r == mop_pkg::MOP_MODE_PULSE;
  wire logic [30:0] inc_nxt = p_live ? 31'(p_abs * marks_r) : 31'h0000_0000;
  wire logic [32:0] acc_sum = acc_r + {2'b00, inc_r};
  wire logic acc_wrap = acc_sum >= `MOP_ACC_MOD;
  wire logic [32:0] acc_nxt = acc_wrap ? acc_sum - `MOP_ACC_MOD : acc_sum;
  // fixed high time makes an unequal pulse-pause ratio
  wire logic [7:0] hi_nxt = acc_wrap ? 8'(`MOP_PULSE_HIGH_CYC)
    : hi_cnt_r != 8'h00 ? hi_cnt_r - 8'h01 : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inc_r <= 31'h0000_0000;
      acc_r <= 33'h0_0000_0000;
      hi_cnt_r <= 8'h00;
      pulse_r <= 1'b0;
    end
    else
    begin
      inc_r <= inc_nxt;
      acc_r <= mode_r == mop_pkg::MOP_MODE_PULSE ? acc_nxt : 33'h0_0000_0000;
      hi_cnt_r <= hi_nxt;
      pulse_r <= hi_nxt != 8'h00 && mode_r == mop_pkg::MOP_MODE_PULSE;
    end
  end

  // pin selector: exactly one source per mode, except off mode which drives low
  wire logic pin_nxt = mode_r == mop_pkg::MOP_MODE_DIG ? digital_level
    : mode_r == mop_pkg::MOP_MODE_ANA ? multi_output_analog_path
    : mode_r == mop_pkg::MOP_MODE_PULSE ? pulse_r
    : 1'b0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
    end
  end

  assign multi_output_pin = pin_r;

  AST_OFF_LOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_r == mop_pkg::MOP_MODE_OFF |=> !multi_output_pin)
    else $error("pin not low in off mode");

  AST_DIG_FOLLOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_r == mop_pkg::MOP_MODE_DIG |=> multi_output_pin == $past(digital_level))
    else $error("pin does not follow the digital level");

  AST_ANA_GATED: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_r != mop_pkg::MOP_MODE_ANA |=> !multi_output_analog_path)
    else $error("analog path active outside analog mode");

  AST_PULSE_GATED: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_r != mop_pkg::MOP_MODE_PULSE |=> !pulse_r && inc_r == 31'h0000_0000)
    else $error("pulse path active outside pulse mode");

  AST_SRC_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    div_done && ana_src_r == 8'h00 |=> volt_r == 8'h00)
    else $error("analog level not zero with source off");

  AST_V_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_take && hit_volt |=> v100_r <= `MOP_V100_MAX && v0_r <= `MOP_V_SAT)
    else $error("voltage setting outside its range");

  AST_SATURATE: assert property (
    @(posedge pclk) disable iff (!presetn)
    div_done && ana_ok && over_sat |=> volt_r == `MOP_V_SAT)
    else $error("overrange level not held at 24 V");

  AST_MARKS_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_take && hit_pulse |=> marks_r >= `MOP_MARKS_MIN && marks_r <= `MOP_MARKS_MAX)
    else $error("division marks outside 30..8192");

  AST_SLOW_SILENT: assert property (
    @(posedge pclk) disable iff (!presetn)
    !p_fast ##1 !p_fast |=> inc_r == 31'h0000_0000 && !acc_wrap)
    else $error("pulses produced below the minimum frequency");

  AST_PULSE_HIGH: assert property (
    @(posedge pclk) disable iff (!presetn || mode_r != mop_pkg::MOP_MODE_PULSE)
    $rose(pulse_r)
      |=> pulse_r [*8])
    else $error("pulse high time too short");

  AST_RATE_STEP: assert property (
    @(posedge pclk) disable iff (!presetn)
    p_live |=> inc_r == 31'($past(p_abs) * $past(marks_r)))
    else $error("accumulator step is not frequency times marks");

  AST_ACC_BOUND: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wrap |=> acc_r < `MOP_ACC_MOD && hi_cnt_r == 8'(`MOP_PULSE_HIGH_CYC))
    else $error("accumulator wrap not taken");
endmodule : mop_top

// >>> sim/mop_eval_dev.sv
// far-side evaluation device: counts pulses on the output pin
// assumes the pin is sampled on pclk and clear is a short pulse
`timescale 1ns/1ns
module mop_eval_dev (
  input wire logic pclk,
  input wire logic pin,
  input wire logic clear,
  output logic [15:0] edges,
  output logic [15:0] high_len
);
  logic pin_q = 1'b0;
  logic [15:0] run = 16'h0000;
  // high and low times differ, so only one edge kind is counted
  always_ff @(posedge pclk)
  begin
    pin_q <= pin;
    if (clear)
      edges <= 16'h0000;
    else if (pin && !pin_q)
      edges <= edges + 16'h0001;
    if (pin && !pin_q)
      run <= 16'h0001;
    else if (pin)
      run <= run + 16'h0001;
    else if (pin_q)
      high_len <= run;
  end
endmodule : mop_eval_dev

// >>> sim/testbench.sv
// self-checking bench of the multifunction output stage
// assumes a 25 MHz pclk and an apb slave that answers by itself
`timescale 1ns/1ns
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mop_pkg::mop_actual_s actual = '0;
  logic digital_level = 1'b0;
  logic multi_output_pin;
  logic clear = 1'b0;
  logic [15:0] edges;
  logic [15:0] high_len;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int n_compared = 0;

  mop_top i_mop_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .actual(actual), .digital_level(digital_level),
    .multi_output_pin(multi_output_pin));
  mop_eval_dev i_mop_eval_dev (.pclk(pclk), .pin(multi_output_pin), .clear(clear),
    .edges(edges), .high_len(high_len));

  always #20 pclk = ~pclk;

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1)
    begin
      failures++;
      wrap_up;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // waits long enough for divider and refresh before the level is read
  task automatic level(input logic [7:0] exp);
    repeat (150) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("analog level", {24'h00_0000, rd[7:0]}, {24'h00_0000, exp});
  endtask : level

  task automatic count_edges;
    @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (5000) @(posedge pclk);
    @(negedge pclk);
  endtask : count_edges

  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("mode default", rd, 32'h0000_0002);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("source default", rd, 32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("span default", rd, 32'h0000_0064);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("marks default", rd, 32'h0400_0000);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
  endtask : t_reset

  task automatic t_modes;
    @(posedge pclk);
    digital_level <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0000);
    repeat (4) @(negedge pclk);
    chk("pin off", {31'h0000_0000, multi_output_pin}, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (3) @(negedge pclk);
    chk("pin digital", {31'h0000_0000, multi_output_pin}, 32'h0000_0001);
    @(posedge pclk);
    digital_level <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("pin follows", {31'h0000_0000, multi_output_pin}, 32'h0000_0000);
  endtask : t_modes

  task automatic t_analog;
    logic [7:0] code [9] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h20, 8'h21, 8'h28, 8'h65, 8'h6B};
    logic [7:0] lv [9] = '{8'h00, 8'h32, 8'h64, 8'h64, 8'h19, 8'h64, 8'h32, 8'h4B, 8'h00};
    int h;
    @(posedge pclk);
    actual.max_freq <= 18'h0_1388;
    actual.stator_freq <= 18'h0_09C4;
    actual.actual_freq <= 18'h3_EC78;
    actual.speed_freq <= 18'h0_1388;
    actual.inside_temp <= 18'h0_00FA;
    actual.sink_temp <= 18'h0_03E8;
    actual.multi_input_analog_value <= 18'h0_01F4;
    apb(1'b1, 12'h000, 32'h0000_0002);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, 12'h004, {24'h00_0000, code[i]});
      level(lv[i]);
    end
    apb(1'b1, 12'h004, 32'h0000_0001);
    actual.stator_freq <= 18'h0_1D4C;
    level(8'h96);
    actual.stator_freq <= 18'h0_3A98;
    level(8'hF0);
    apb(1'b1, 12'h008, 32'h0000_14FF);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("span clamp", rd, 32'h0000_14DC);
    actual.stator_freq <= 18'h0_09C4;
    level(8'h78);
    // band code: (30 Hz - 10 Hz) over (50 Hz - 10 Hz) is half scale
    actual.min_freq <= 18'h0_03E8;
    actual.stator_freq <= 18'h0_0BB8;
    apb(1'b1, 12'h004, 32'h0000_0002);
    level(8'h78);
    repeat (480) @(posedge pclk);
    h = 0;
    repeat (240)
    begin
      @(negedge pclk);
      if (multi_output_pin === 1'b1)
        h++;
    end
    chk("pwm high clocks", 32'(h), 32'h0000_0078);
  endtask : t_analog

  task automatic t_pulse;
    logic [2:0] src [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    @(posedge pclk);
    actual.actual_freq <= 18'h2_7960;
    actual.stator_freq <= 18'h2_7960;
    actual.enc1_freq <= 18'h2_7960;
    actual.pulse_in_freq <= 18'h2_7960;
    apb(1'b1, 12'h000, 32'h0000_0003);
    // 1000 Hz times 100 marks stays under 150 kHz
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 12'h00C, {16'h0064, 13'h0000, src[i]});
      count_edges;
      chk("pulse count", 32'(edges > 16'h0012 && edges < 16'h0016), 32'(i > 0));
    end
    chk("pulse high", {16'h0000, high_len}, 32'h0000_0032);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("pulse live", {31'h0000_0000, rd[8]}, 32'h0000_0001);
    actual.actual_freq <= 18'h0_0BB7;
    apb(1'b1, 12'h00C, 32'h1000_0001);
    count_edges;
    chk("below min", {16'h0000, edges}, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("slow not live", {31'h0000_0000, rd[8]}, 32'h0000_0000);
    actual.actual_freq <= 18'h0_0BB8;
    count_edges;
    chk("at min", 32'(edges > 16'h0016 && edges < 16'h001B), 32'h0000_0001);
    apb(1'b1, 12'h00C, 32'h000A_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("marks clamp", rd, 32'h001E_0001);
    apb(1'b1, 12'h000, 32'h0000_0000);
    count_edges;
    chk("pulse stops", {16'h0000, edges}, 32'h0000_0000);
  endtask : t_pulse

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_modes;
    t_analog;
    t_pulse;
    wrap_up;
  end
endmodule : testbench
